/* verilog/rtc1b_params.svh */
// constants of the one-bit serial host port: bit counts, command codes, mode codes
`ifndef RTC1B_PARAMS_SVH
`define RTC1B_PARAMS_SVH

// -----------------------------------------------------------------------------
// cycle framing
// -----------------------------------------------------------------------------
`define RTC1B_ADDR_BITS 4
`define RTC1B_DATA_BITS 8
`define RTC1B_ADDR_LAST 2'h3
`define RTC1B_DATA_LAST 3'h7

// -----------------------------------------------------------------------------
// address command codes
// -----------------------------------------------------------------------------
`define RTC1B_CMD_LOAD_TIME 4'he
`define RTC1B_CMD_SNAPSHOT 4'hf

// -----------------------------------------------------------------------------
// bus mode codes and buffer sizing
// -----------------------------------------------------------------------------
`define RTC1B_MODE_STROBE_PAIR 2'h0
`define RTC1B_MODE_DIR_STROBE 2'h1
`define RTC1B_MODE_DIR_SELECT 2'h2
`define RTC1B_BUF_DEPTH 2
`define RTC1B_PIN_IDLE 4'hf

`endif

/* verilog/rtc1b_pkg.sv */
// types shared by the one-bit serial host port
`include "rtc1b_params.svh"

package rtc1b_pkg;

  // strapped bus timing flavour
  typedef enum logic [1:0] {
    BM_STROBE_PAIR = 2'b00,
    BM_DIR_STROBE  = 2'b01,
    BM_DIR_SELECT  = 2'b10
  } rtc1b_mode_type;

  // bit sequencer states
  typedef enum logic [1:0] {
    ST_ADDR  = 2'b00,
    ST_FETCH = 2'b01,
    ST_DATA  = 2'b10,
    ST_PUSH  = 2'b11
  } rtc1b_state_type;

  // what a finished cycle asks of the core
  typedef enum logic [1:0] {
    EV_WRITE    = 2'b00,
    EV_LOAD     = 2'b01,
    EV_SNAPSHOT = 2'b10
  } rtc1b_kind_type;

  typedef struct packed {
    rtc1b_kind_type kind;
    logic [`RTC1B_ADDR_BITS-1:0] addr;
    logic [`RTC1B_DATA_BITS-1:0] data;
  } rtc1b_evt_type;

  // filtered pin levels
  typedef struct packed {
    logic sel_n;
    logic rd_n;
    logic wr_n;
    logic line;
  } rtc1b_pins_type;

endpackage

/* verilog/rtc1b_pin_sync.sv */
// three-flop pin synchroniser with second/third stage agreement filter
module rtc1b_pin_sync #(
  parameter int W = 4,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] level_o
);

  logic [W-1:0] ff1_r;
  logic [W-1:0] ff2_r;
  logic [W-1:0] ff3_r;
  logic [W-1:0] level_r;

  // ff1 feeds ff2 only; a bit changes once ff2 and ff3 agree
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ff1_r <= RST_VAL;
      ff2_r <= RST_VAL;
      ff3_r <= RST_VAL;
      level_r <= RST_VAL;
    end
    else
    begin
      ff1_r <= async_i;
      ff2_r <= ff1_r;
      ff3_r <= ff2_r;
      level_r <= (ff2_r & ~(ff2_r ^ ff3_r)) | (level_r & (ff2_r ^ ff3_r));
    end
  end

  assign level_o = level_r;

endmodule

/* verilog/rtc1b_skid_buf.sv */
// small flop-based fifo with valid/ready on both sides
module rtc1b_skid_buf #(
  parameter int W = 14,
  parameter int DEPTH = 2
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  logic [W-1:0] mem_r [DEPTH];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [CW-1:0] count_r;
  logic push;
  logic pop;

  function automatic logic [PW-1:0] ptr_step(input logic [PW-1:0] p);
    ptr_step = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  // honest flags: ready drops only when every entry is taken
  assign in_ready_o = (count_r != FULL);
  assign out_valid_o = (count_r != '0);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem_r[rd_ptr_r];

  // storage
  always_ff @(posedge clk_i)
  begin
    if (push)
      mem_r[wr_ptr_r] <= in_data_i;
  end

  // pointers and fill level
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_r <= ptr_step(wr_ptr_r);
      if (pop)
        rd_ptr_r <= ptr_step(rd_ptr_r);
      if (push && !pop)
        count_r <= count_r + 1'b1;
      else if (pop && !push)
        count_r <= count_r - 1'b1;
    end
  end

endmodule

/* verilog/rtc1b_serial_port.sv */
// one-bit bus serial host port: pin framing, bit sequencer, cycle decode
//
// Functional notes
// - strobes count only while device select is low
// - strobe-pair mode: each read or store strobe with select moves one bit
// - direction mode: bus strobe plus select frame a bit, direction picks way
// - select-only mode: read strobe tied to select, select alone frames bits
// - all address and data bits travel on one bidirectional serial line
// - a three-wire serial master can drive the same bit protocol
// - three cycle kinds: read data, write data, address-only command
// - every cycle opens with four written address bits
// - a read while awaiting the first address bit starts nothing
// - data cycles are four address bits then eight data bits
// - the four address bits pick the location the data bits use
// - a command cycle ends after four address bits
// - store strobe pin is write strobe or direction input by mode
// - write bit active while both asserted, captured at first deassert
// - line driven only while read strobe and select both asserted; the drive trails the filtered read window by one cycle
// - address bits go least significant first
// - data bits go least significant first; eighth bit ends the cycle
// - after fourth address bit, codes e and f end cycle and run a copy
`include "rtc1b_params.svh"

module rtc1b_serial_port #(
  parameter int BUF_DEPTH = `RTC1B_BUF_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire rtc1b_pkg::rtc1b_mode_type bus_mode_i,
  input wire logic device_select_n_i,
  input wire logic read_strobe_n_i,
  input wire logic store_strobe_n_i,
  input wire logic serial_line_i,
  output logic serial_line_o,
  output logic serial_line_oe_o,
  output logic [`RTC1B_ADDR_BITS-1:0] ram_rd_addr_o,
  input wire logic [`RTC1B_DATA_BITS-1:0] ram_rd_data_i,
  output logic evt_valid_o,
  input wire logic evt_ready_i,
  output rtc1b_pkg::rtc1b_evt_type evt_o,
  output logic stall_o
);

  // ---------------------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------------------
  localparam int EVT_W = $bits(rtc1b_pkg::rtc1b_evt_type);

  // filtered pins and sequencer state
  rtc1b_pkg::rtc1b_pins_type pins;
  rtc1b_pkg::rtc1b_state_type st_r;
  rtc1b_pkg::rtc1b_state_type st_nxt;
  rtc1b_pkg::rtc1b_evt_type evt_r;
  rtc1b_pkg::rtc1b_evt_type evt_nxt;
  logic [2:0] bit_cnt_r;
  logic [2:0] bit_cnt_nxt;
  // shift registers for the cycle in progress
  logic [`RTC1B_ADDR_BITS-1:0] addr_r;
  logic [`RTC1B_ADDR_BITS-1:0] addr_full;
  logic [`RTC1B_DATA_BITS-1:0] data_r;
  logic wrote_r;
  logic wbit_r;
  // window levels and their closing edges
  logic rd_act;
  logic wr_act;
  logic rd_act_r;
  logic wr_act_r;
  logic rd_done;
  logic wr_done;
  // line drive and buffer handshake
  logic line_r;
  logic oe_r;
  logic buf_in_ready;
  logic [EVT_W-1:0] buf_out;

  // ---------------------------------------------------------------------------
  // pin conditioning
  // ---------------------------------------------------------------------------
  // all four pins are asynchronous to clk_i, so each passes the filter
  rtc1b_pin_sync #(
    .W(4),
    .RST_VAL(`RTC1B_PIN_IDLE)
  ) u_pin_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .async_i({device_select_n_i, read_strobe_n_i, store_strobe_n_i, serial_line_i}),
    .level_o(pins)
  );

  // ---------------------------------------------------------------------------
  // strobe decode per bus mode
  // ---------------------------------------------------------------------------
  // a three-wire serial master fits the select-only mode: its strobe drives
  // select, the store pin gives direction and the line carries data
  // read transfer window for the strapped mode
  function automatic logic read_window(input rtc1b_pkg::rtc1b_mode_type m,
                                       input rtc1b_pkg::rtc1b_pins_type p);
    logic sel;
    sel = !p.sel_n;
    case (m)
      rtc1b_pkg::BM_STROBE_PAIR: read_window = sel && !p.rd_n;
      rtc1b_pkg::BM_DIR_STROBE: read_window = sel && !p.rd_n && p.wr_n;
      rtc1b_pkg::BM_DIR_SELECT: read_window = sel && p.wr_n;
      default: read_window = 1'b0;
    endcase
  endfunction

  // write transfer window for the strapped mode
  function automatic logic write_window(input rtc1b_pkg::rtc1b_mode_type m,
                                        input rtc1b_pkg::rtc1b_pins_type p);
    logic sel;
    sel = !p.sel_n;
    case (m)
      rtc1b_pkg::BM_STROBE_PAIR: write_window = sel && !p.wr_n;
      rtc1b_pkg::BM_DIR_STROBE: write_window = sel && !p.rd_n && !p.wr_n;
      rtc1b_pkg::BM_DIR_SELECT: write_window = sel && !p.wr_n;
      default: write_window = 1'b0;
    endcase
  endfunction

  // select gates every window, so strobes alone never count
  assign rd_act = read_window(bus_mode_i, pins);
  assign wr_act = write_window(bus_mode_i, pins);

  // ---------------------------------------------------------------------------
  // transfer edges
  // ---------------------------------------------------------------------------
  // a bit is done when its window closes, whichever pin lets go first;
  // a window shorter than two clocks never shows up here, since ff2 and ff3 must agree, so
  // the host must hold each strobe for several clocks
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rd_act_r <= 1'b0;
      wr_act_r <= 1'b0;
    end
    else
    begin
      rd_act_r <= rd_act;
      wr_act_r <= wr_act;
    end
  end

  // while parked on a full buffer the sequencer ignores the pins
  assign rd_done = rd_act_r && !rd_act && (st_r != rtc1b_pkg::ST_PUSH);
  assign wr_done = wr_act_r && !wr_act && (st_r != rtc1b_pkg::ST_PUSH);

  // last line level seen inside the write window; hold time covers the close
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      wbit_r <= 1'b0;
    else if (wr_act)
      wbit_r <= pins.line;
  end

  // ---------------------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------------------
  // the last address bit still sits in wbit_r when its window closes, so the
  // complete address is formed here rather than read back a cycle later
  function automatic logic [`RTC1B_ADDR_BITS-1:0] full_addr(input logic last_bit,
    input logic [`RTC1B_ADDR_BITS-1:0] a);
    full_addr = {last_bit, a[`RTC1B_ADDR_BITS-2:0]};
  endfunction

  assign addr_full = full_addr(wbit_r, addr_r);

  // ---------------------------------------------------------------------------
  // bit sequencer
  // ---------------------------------------------------------------------------
  // next state, bit position and pending event
  // limitation: a window that closes in the fetch cycle or while parked in
  // push is dropped, so hosts must keep their bits well apart
  always_comb
  begin
    st_nxt = st_r;
    bit_cnt_nxt = bit_cnt_r;
    evt_nxt = evt_r;
    case (st_r)
      rtc1b_pkg::ST_ADDR:
      begin
        if (wr_done)
        begin
          if (bit_cnt_r[1:0] == `RTC1B_ADDR_LAST)
          begin
            bit_cnt_nxt = 3'h0;
            evt_nxt.addr = addr_full;
            evt_nxt.data = 8'h00;
            if (addr_full == `RTC1B_CMD_LOAD_TIME)
            begin
              evt_nxt.kind = rtc1b_pkg::EV_LOAD;
              st_nxt = rtc1b_pkg::ST_PUSH;
            end
            else if (addr_full == `RTC1B_CMD_SNAPSHOT)
            begin
              evt_nxt.kind = rtc1b_pkg::EV_SNAPSHOT;
              st_nxt = rtc1b_pkg::ST_PUSH;
            end
            else
              st_nxt = rtc1b_pkg::ST_FETCH;
          end
          else
            bit_cnt_nxt = bit_cnt_r + 3'h1;
        end
        else if (rd_done && bit_cnt_r != 3'h0)
          bit_cnt_nxt = 3'h0;
        // a read at bit zero leaves everything as it is
      end
      // one cycle for the ram byte to land in data_r
      rtc1b_pkg::ST_FETCH:
        st_nxt = rtc1b_pkg::ST_DATA;
      rtc1b_pkg::ST_DATA:
      begin
        if (wr_done || rd_done)
        begin
          if (bit_cnt_r == `RTC1B_DATA_LAST)
          begin
            bit_cnt_nxt = 3'h0;
            evt_nxt.kind = rtc1b_pkg::EV_WRITE;
            evt_nxt.addr = addr_r;
            // reads keep the fetched bits, writes have replaced theirs
            evt_nxt.data = {wr_done ? wbit_r : data_r[7], data_r[6:0]};
            if (wr_done || wrote_r)
              st_nxt = rtc1b_pkg::ST_PUSH;
            else
              st_nxt = rtc1b_pkg::ST_ADDR;
          end
          else
            bit_cnt_nxt = bit_cnt_r + 3'h1;
        end
      end
      rtc1b_pkg::ST_PUSH:
      begin
        // the push is taken in this very cycle when the buffer has room
        if (buf_in_ready)
          st_nxt = rtc1b_pkg::ST_ADDR;
      end
      default:
        st_nxt = rtc1b_pkg::ST_ADDR;
    endcase
  end

  // state, position and event registers
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_r <= rtc1b_pkg::ST_ADDR;
      bit_cnt_r <= 3'h0;
      evt_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      evt_r <= evt_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // address and data shift
  // ---------------------------------------------------------------------------
  // address assembles lsb first at the bit position
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      addr_r <= 4'h0;
    else if (st_r == rtc1b_pkg::ST_ADDR && wr_done)
      addr_r[bit_cnt_r[1:0]] <= wbit_r;
  end

  // fetch loads the location once, then bits are read or replaced in place
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      data_r <= 8'h00;
      wrote_r <= 1'b0;
    end
    else if (st_r == rtc1b_pkg::ST_FETCH)
    begin
      data_r <= ram_rd_data_i;
      wrote_r <= 1'b0;
    end
    else if (st_r == rtc1b_pkg::ST_DATA && wr_done)
    begin
      data_r[bit_cnt_r] <= wbit_r;
      wrote_r <= 1'b1;
    end
  end

  // read port address straight from the assembled address
  assign ram_rd_addr_o = addr_r;

  // ---------------------------------------------------------------------------
  // serial line drive
  // ---------------------------------------------------------------------------
  // registered drive; releases a few cycles after the window closes
  // the release trails the window by the filter depth plus this register,
  // so a host must leave a gap before it drives the line itself
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      line_r <= 1'b0;
      oe_r <= 1'b0;
    end
    else
    begin
      line_r <= data_r[bit_cnt_r];
      oe_r <= rd_act;
    end
  end

  assign serial_line_o = line_r;
  assign serial_line_oe_o = oe_r;

  // ---------------------------------------------------------------------------
  // event buffer toward the core
  // ---------------------------------------------------------------------------
  // the core may stall; the sequencer then waits in the push state
  // two entries let the core skip a cycle without holding up the host
  rtc1b_skid_buf #(
    .W(EVT_W),
    .DEPTH(BUF_DEPTH)
  ) u_evt_buf (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(st_r == rtc1b_pkg::ST_PUSH),
    .in_ready_o(buf_in_ready),
    .in_data_i(evt_r),
    .out_valid_o(evt_valid_o),
    .out_ready_i(evt_ready_i),
    .out_data_o(buf_out)
  );

  assign evt_o = rtc1b_pkg::rtc1b_evt_type'(buf_out);

  // host bits arriving during a stall are lost, so flag it
  assign stall_o = (st_r == rtc1b_pkg::ST_PUSH) && !buf_in_ready;

endmodule

/* verification/rtc1b_serial_port_chk.sv */
// concurrent checks on the host port pins and event outputs
`include "rtc1b_params.svh"

module rtc1b_chk #(
  parameter int BUF_DEPTH = 2
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire rtc1b_pkg::rtc1b_mode_type bus_mode_i,
  input wire logic device_select_n_i,
  input wire logic read_strobe_n_i,
  input wire logic store_strobe_n_i,
  input wire logic serial_line_oe_o,
  input wire logic evt_valid_o,
  input wire logic evt_ready_i,
  input wire rtc1b_pkg::rtc1b_evt_type evt_o,
  input wire logic stall_o
);
  // ----------------------------------------
  // quiet pin sequences
  // ----------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // eight idle cycles outlast the filter plus the output register
  sequence s_sel_idle;
    device_select_n_i [*8];
  endsequence
  sequence s_rd_idle;
    read_strobe_n_i [*8];
  endsequence
  sequence s_dir_write;
    (!store_strobe_n_i && bus_mode_i != rtc1b_pkg::BM_STROBE_PAIR) [*8];
  endsequence
  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_oe_needs_select: assert property ($rose(serial_line_oe_o) |-> $past(!device_select_n_i, 3))
    else $error("line driven without device select");
  a_oe_needs_read: assert property ($rose(serial_line_oe_o) |-> $past(!read_strobe_n_i && store_strobe_n_i, 3))
    else $error("line driven outside a read window");
  a_oe_sel_release: assert property (s_sel_idle |=> !serial_line_oe_o)
    else $error("line still driven after select went high");
  a_oe_rd_release: assert property (s_rd_idle |=> !serial_line_oe_o)
    else $error("line still driven after read strobe went high");
  a_oe_dir_write: assert property (s_dir_write |=> !serial_line_oe_o)
    else $error("line driven while direction says write");
  a_load_addr: assert property (evt_valid_o && evt_o.kind == rtc1b_pkg::EV_LOAD |-> evt_o.addr == `RTC1B_CMD_LOAD_TIME)
    else $error("load event with wrong address");
  a_snap_addr: assert property (evt_valid_o && evt_o.kind == rtc1b_pkg::EV_SNAPSHOT |-> evt_o.addr == `RTC1B_CMD_SNAPSHOT)
    else $error("snapshot event with wrong address");
  a_write_data_addr: assert property (evt_valid_o && evt_o.kind == rtc1b_pkg::EV_WRITE |-> evt_o.addr < 4'he)
    else $error("write event at a command address");
  a_kind_legal: assert property (evt_valid_o |-> evt_o.kind != 2'h3)
    else $error("event of unknown kind");
  a_head_holds: assert property (evt_valid_o && !evt_ready_i |=> evt_valid_o && $stable(evt_o))
    else $error("event head changed while not taken");
  a_stall_full: assert property (stall_o |-> evt_valid_o)
    else $error("stall with an empty buffer");
endmodule

bind rtc1b_serial_port rtc1b_chk #(.BUF_DEPTH(BUF_DEPTH)) u_rtc1b_chk (
  .clk_i(clk_i),
  .rst_n_i(rst_n_i),
  .bus_mode_i(bus_mode_i),
  .device_select_n_i(device_select_n_i),
  .read_strobe_n_i(read_strobe_n_i),
  .store_strobe_n_i(store_strobe_n_i),
  .serial_line_oe_o(serial_line_oe_o),
  .evt_valid_o(evt_valid_o),
  .evt_ready_i(evt_ready_i),
  .evt_o(evt_o),
  .stall_o(stall_o)
);

/* verification/rtc1b_host_model.sv */
// host bus master model: frames one-bit transfers on the port pins
module rtc1b_host_model (
  input wire logic clk_i,
  input wire rtc1b_pkg::rtc1b_mode_type mode_i,
  input wire logic dev_line_i,
  input wire logic dev_oe_i,
  output logic sel_n_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic line_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sel_n_r = 1'b1;
  logic rd_n_r = 1'b1;
  logic wr_n_r = 1'b1;
  logic drv_r = 1'b0;
  logic val_r = 1'b0;
  logic last_r = 1'b0;
  // ----------------------------------------
  // pins and line level
  // ----------------------------------------
  // read pin tied to select in the select-only mode
  assign rd_n_o = (mode_i == rtc1b_pkg::BM_DIR_SELECT) ? sel_n_r : rd_n_r;
  assign sel_n_o = sel_n_r;
  assign wr_n_o = wr_n_r;
  // a floating line toggles so a stale bit never reads as valid
  assign line_o = dev_oe_i ? dev_line_i : (drv_r ? val_r : ~last_r);
  always @(posedge clk_i)
    last_r <= line_o;
  // ----------------------------------------
  // one bit transfer, windows of ten cycles and gaps of nineteen cycles
  // ----------------------------------------
  task automatic xfer(input logic is_wr, input logic v, output logic got);
    @(posedge clk_i);
    if (mode_i != rtc1b_pkg::BM_STROBE_PAIR)
      wr_n_r <= ~is_wr;
    drv_r <= is_wr;
    val_r <= v;
    repeat (2) @(posedge clk_i);
    sel_n_r <= 1'b0;
    if (mode_i == rtc1b_pkg::BM_STROBE_PAIR && is_wr)
      wr_n_r <= 1'b0;
    else if (mode_i != rtc1b_pkg::BM_DIR_SELECT)
      rd_n_r <= 1'b0;
    repeat (10) @(posedge clk_i);
    got = line_o;
    sel_n_r <= 1'b1;
    rd_n_r <= 1'b1;
    if (mode_i == rtc1b_pkg::BM_STROBE_PAIR)
      wr_n_r <= 1'b1;
    // write data held past the close
    repeat (6) @(posedge clk_i);
    drv_r <= 1'b0;
    repeat (10) @(posedge clk_i);
  endtask
endmodule

/* verification/rtc1b_tb.sv */
// self-checking bench for the one-bit serial host port
`include "rtc1b_params.svh"
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin err_total++; $display("MISMATCH %s exp %h got %h", nm, ex, gt); end end

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  rtc1b_pkg::rtc1b_mode_type mode = rtc1b_pkg::BM_STROBE_PAIR;
  logic sel_n, rd_n, wr_n, line, dev_o, dev_oe, evt_valid, stall;
  logic evt_ready = 1'b0;
  logic [7:0] ram_data = 8'h00;
  logic [3:0] ram_addr;
  rtc1b_pkg::rtc1b_evt_type evt;
  int err_total = 0;
  int num_checks = 0;
  // ----------------------------------------
  // clock, design and host
  // ----------------------------------------
  always #5 clk = ~clk;
  rtc1b_serial_port #(.BUF_DEPTH(2)) u_rtc1b_serial_port (.clk_i(clk), .rst_n_i(rst_n), .bus_mode_i(mode),
    .device_select_n_i(sel_n), .read_strobe_n_i(rd_n), .store_strobe_n_i(wr_n), .serial_line_i(line),
    .serial_line_o(dev_o), .serial_line_oe_o(dev_oe), .ram_rd_addr_o(ram_addr), .ram_rd_data_i(ram_data),
    .evt_valid_o(evt_valid), .evt_ready_i(evt_ready), .evt_o(evt), .stall_o(stall));
  rtc1b_host_model u_rtc1b_host_model (.clk_i(clk), .mode_i(mode), .dev_line_i(dev_o), .dev_oe_i(dev_oe),
    .sel_n_o(sel_n), .rd_n_o(rd_n), .wr_n_o(wr_n), .line_o(line));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic do_reset(input rtc1b_pkg::rtc1b_mode_type m);
    @(posedge clk);
    rst_n <= 1'b0;
    mode <= m;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask
  task automatic put_addr(input logic [3:0] a);
    logic g;
    for (int i = 0; i < 4; i++)
      u_rtc1b_host_model.xfer(1'b1, a[i], g);
  endtask
  task automatic put_data(input logic [7:0] d);
    logic g;
    for (int i = 0; i < 8; i++)
      u_rtc1b_host_model.xfer(1'b1, d[i], g);
  endtask
  task automatic get_data(output logic [7:0] d);
    for (int i = 0; i < 8; i++)
      u_rtc1b_host_model.xfer(1'b0, 1'b0, d[i]);
  endtask
  // bounded wait for the head, compare, then hand it over
  task automatic take_evt(input rtc1b_pkg::rtc1b_kind_type k, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (evt_valid !== 1'b1 && n < 200)
    begin
      @(posedge clk);
      n++;
    end
    `CHK("evt_valid", 1'b1, evt_valid)
    `CHK("evt_kind", k, evt.kind)
    `CHK("evt_addr", a, evt.addr)
    if (k == rtc1b_pkg::EV_WRITE)
      `CHK("evt_data", d, evt.data)
    evt_ready <= 1'b1;
    @(posedge clk);
    evt_ready <= 1'b0;
    @(posedge clk);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // a leading read must not count as an address bit
  task automatic t_write_modes();
    logic g;
    logic [7:0] d;
    for (int i = 0; i < 3; i++)
    begin
      do_reset(rtc1b_pkg::rtc1b_mode_type'(i));
      u_rtc1b_host_model.xfer(1'b0, 1'b0, g);
      put_addr(4'h3);
      put_data(8'ha5);
      take_evt(rtc1b_pkg::EV_WRITE, 4'h3, 8'ha5);
      ram_data <= 8'hc3 ^ 8'(i);
      put_addr(4'h6);
      get_data(d);
      `CHK("mode_read", 8'hc3 ^ 8'(i), d)
    end
  endtask
  task automatic t_read();
    logic [7:0] d;
    ram_data <= 8'h3c;
    put_addr(4'h5);
    `CHK("ram_addr", 4'h5, ram_addr)
    get_data(d);
    `CHK("read_byte", 8'h3c, d)
    `CHK("no_evt", 1'b0, evt_valid)
  endtask
  // commands end after four bits; next cycle starts at bit zero
  task automatic t_commands();
    put_addr(4'he);
    take_evt(rtc1b_pkg::EV_LOAD, 4'he, 8'h00);
    put_addr(4'hf);
    take_evt(rtc1b_pkg::EV_SNAPSHOT, 4'hf, 8'h00);
    put_addr(4'h9);
    put_data(8'h96);
    take_evt(rtc1b_pkg::EV_WRITE, 4'h9, 8'h96);
  endtask
  task automatic t_resync();
    logic [7:0] d;
    logic g;
    u_rtc1b_host_model.xfer(1'b1, 1'b1, g);
    u_rtc1b_host_model.xfer(1'b1, 1'b0, g);
    get_data(d);
    put_addr(4'h2);
    for (int i = 0; i < 3; i++)
      u_rtc1b_host_model.xfer(1'b0, 1'b0, g);
    get_data(d);
    `CHK("resync_no_evt", 1'b0, evt_valid)
    put_addr(4'h7);
    put_data(8'h5a);
    take_evt(rtc1b_pkg::EV_WRITE, 4'h7, 8'h5a);
  endtask
  // third cycle meets a full buffer and stalls; order kept
  task automatic t_buffer();
    for (int i = 0; i < 3; i++)
    begin
      put_addr(4'(i + 1));
      put_data(8'(8'h11 * (i + 1)));
    end
    `CHK("stall", 1'b1, stall)
    for (int i = 0; i < 3; i++)
      take_evt(rtc1b_pkg::EV_WRITE, 4'(i + 1), 8'(8'h11 * (i + 1)));
    `CHK("stall_clear", 1'b0, stall)
    `CHK("buf_empty", 1'b0, evt_valid)
  endtask
  // ----------------------------------------
  // sequence, watchdog, verdict
  // ----------------------------------------
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    t_write_modes();
    t_read();
    t_commands();
    t_resync();
    t_buffer();
    finish_test();
  end
  // run needs about 5300 cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    finish_test();
  end
endmodule
